// file: design/krtc_pkg.sv
/*
 * constants and carrier types for the keypad reset and trip clear block.
 * assumes a single 250 MHz clock and synchronous active-low reset.
 */
`default_nettype none
package krtc_pkg;
    localparam int unsigned CLK_MHZ            = 250;
    localparam int unsigned HOLD_MS            = 2000;
    localparam int unsigned HOLD_CYCLES        = HOLD_MS * 1000 * CLK_MHZ;
    localparam logic [3:0]  UDC_SAVE           = 4'h1;
    localparam logic [3:0]  UDC_CLEAR          = 4'h2;
    localparam logic [3:0]  SRC_FIELDBUS       = 4'h4;
    localparam logic [3:0]  SRC_BACNET         = 4'h6;
    localparam logic [3:0]  SRC_KEYPAD         = 4'h0;
    localparam logic [3:0]  INCFG_OFF          = 4'h0;

    typedef struct packed {
        logic up;
        logic down;
        logic start;
        logic stop;
        logic hand;
        logic auto_key;
        logic nav;
    } krtc_keys_type;

    typedef enum logic [3:0] {
        KRTC_IDLE    = 4'b0001,
        KRTC_HOLD    = 4'b0010,
        KRTC_PROMPT  = 4'b0100,
        KRTC_RELEASE = 4'b1000
    } krtc_state_type;

    typedef enum logic [1:0] {
        DISP_RUN     = 2'h0,
        DISP_PDEF    = 2'h1,
        DISP_UDEF    = 2'h2,
        DISP_FAULT   = 2'h3
    } krtc_disp_type;

    typedef struct packed {
        krtc_keys_type  keys_s1;
        krtc_keys_type  keys_s2;
        krtc_keys_type  keys_prev;
        logic           din1_s1;
        logic           din1_s2;
        logic           din1_prev;
        krtc_state_type state;
        logic           user_chord;
        logic [31:0]    hold_cnt;
        logic           user_present;
        logic           tripped;
        logic [7:0]     fault_code;
        logic           hand_mode;
        logic           save_req;
        logic           erase_req;
        logic           factory_req;
        logic           user_req;
    } krtc_regs_type;
endpackage
`default_nettype wire

// file: design/krtc_core.sv
/*
 * keypad chord interpreter: user-default store/erase, factory and user
 * restores, latched trip with multi-source clear, hand/auto selection.
 * assumes keypad and digital input pins are asynchronous (synchronised
 * here), parameter values and fieldbus/bacnet strobes come from logic on
 * mclk, and the parameter memory acts on one-cycle request pulses.
 */
`default_nettype none
// Overview of operation
// - writing 1 to user_default_command copies all parameters into the user store
// - writing 2 to user_default_command erases the user store and marks it absent
// - up+start+stop held over 2 s shows factory prompt; stop then restores factory
// - up+down+stop held over 2 s shows user prompt; stop then loads user defaults
// - user restore with no stored user set performs a factory restore instead
// - any protection event latches a trip, stops output and shows the fault while no restore prompt is displayed
// - keypad stop press clears a latched trip when no chord hold or prompt is in progress
// - input config above 0: digital input 1 off-then-on clears the trip
// - control source 4: fieldbus reset command clears the trip
// - control source 6: bacnet reset command clears the trip
// - hand selects keypad, auto selects configured source, unless access lock forbids or a chord hold or prompt is in progress
module krtc_core
    import krtc_pkg::*;
#(
    parameter int unsigned HOLD_COUNT = HOLD_CYCLES
) (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_b,
    // keypad pins
    input  wire krtc_keys_type keys_pin,
    // digital input pin
    input  wire logic          din1_pin,
    // parameter values and write strobe
    input  wire logic [3:0]    user_default_command,
    input  wire logic          user_default_command_wr,
    input  wire logic [3:0]    input_config_select,
    input  wire logic [3:0]    control_source_select,
    input  wire logic          parameter_access_lock,
    // protection and remote reset strobes
    input  wire logic          protect_event,
    input  wire logic [7:0]    protect_code,
    input  wire logic          fieldbus_reset,
    input  wire logic          bacnet_reset,
    // parameter memory requests
    output logic               user_save_pulse,
    output logic               user_erase_pulse,
    output logic               factory_restore_pulse,
    output logic               user_restore_pulse,
    output logic               user_set_present,
    // drive status
    output logic               trip_latched,
    output logic               output_enable,
    output logic [7:0]         fault_code,
    output krtc_disp_type      display_mode,
    output logic [3:0]         active_source
);
    // the hold compare needs a count of at least two cycles
    if (HOLD_COUNT < 2) begin : g_bad_hold
        $error("HOLD_COUNT must be at least 2");
    end

    krtc_regs_type cur_ff;
    krtc_regs_type nxt_cur;
    krtc_keys_type k;
    krtc_keys_type kp;
    logic          stop_press;
    logic          other_press;
    logic          fac_chord;
    logic          usr_chord;

    always_comb begin
        nxt_cur = cur_ff;
        k  = cur_ff.keys_s2;
        kp = cur_ff.keys_prev;
        stop_press  = k.stop & ~kp.stop;
        other_press = (k.up & ~kp.up) | (k.down & ~kp.down) | (k.start & ~kp.start)
                    | (k.hand & ~kp.hand) | (k.auto_key & ~kp.auto_key)
                    | (k.nav & ~kp.nav);
        fac_chord = k.up & k.start & k.stop & ~k.down;
        usr_chord = k.up & k.down & k.stop & ~k.start;

        nxt_cur.keys_s1   = keys_pin;
        nxt_cur.keys_s2   = cur_ff.keys_s1;
        nxt_cur.keys_prev = cur_ff.keys_s2;
        nxt_cur.din1_s1   = din1_pin;
        nxt_cur.din1_s2   = cur_ff.din1_s1;
        nxt_cur.din1_prev = cur_ff.din1_s2;
        nxt_cur.save_req    = 1'b0;
        nxt_cur.erase_req   = 1'b0;
        nxt_cur.factory_req = 1'b0;
        nxt_cur.user_req    = 1'b0;

        if (user_default_command_wr && user_default_command == UDC_SAVE) begin
            nxt_cur.save_req     = 1'b1;
            nxt_cur.user_present = 1'b1;
        end
        if (user_default_command_wr && user_default_command == UDC_CLEAR) begin
            nxt_cur.erase_req    = 1'b1;
            nxt_cur.user_present = 1'b0;
        end

        unique case (cur_ff.state)
            KRTC_IDLE: begin
                nxt_cur.hold_cnt = '0;
                if (fac_chord || usr_chord) begin
                    nxt_cur.state      = KRTC_HOLD;
                    nxt_cur.user_chord = usr_chord;
                end
            end
            KRTC_HOLD: begin
                // chord must stay the same in up, down, start and stop for the whole hold
                if ((cur_ff.user_chord ? usr_chord : fac_chord)) begin
                    if (cur_ff.hold_cnt >= HOLD_COUNT - 1) begin
                        nxt_cur.state = KRTC_RELEASE;
                    end else begin
                        nxt_cur.hold_cnt = cur_ff.hold_cnt + 32'h0000_0001;
                    end
                end else begin
                    nxt_cur.state = KRTC_IDLE;
                end
            end
            KRTC_RELEASE: begin
                // prompt shown; wait for every key to lift before taking stop
                if (k == '0) nxt_cur.state = KRTC_PROMPT;
            end
            KRTC_PROMPT: begin
                if (other_press) begin
                    nxt_cur.state = KRTC_IDLE;
                end else if (stop_press) begin
                    nxt_cur.state = KRTC_IDLE;
                    if (cur_ff.user_chord && cur_ff.user_present) begin
                        nxt_cur.user_req = 1'b1;
                    end else begin
                        nxt_cur.factory_req = 1'b1;
                    end
                end
            end
        endcase

        // clears come first so a protection event in the same cycle still trips
        if (cur_ff.tripped) begin
            if (stop_press && cur_ff.state == KRTC_IDLE) begin
                nxt_cur.tripped = 1'b0;
            end
            if (input_config_select != INCFG_OFF && cur_ff.din1_s2
                && !cur_ff.din1_prev) begin
                nxt_cur.tripped = 1'b0;
            end
            if (control_source_select == SRC_FIELDBUS && fieldbus_reset) begin
                nxt_cur.tripped = 1'b0;
            end
            if (control_source_select == SRC_BACNET && bacnet_reset) begin
                nxt_cur.tripped = 1'b0;
            end
        end
        if (protect_event) begin
            nxt_cur.tripped    = 1'b1;
            nxt_cur.fault_code = protect_code;
        end

        if (!parameter_access_lock && cur_ff.state == KRTC_IDLE) begin
            if (k.hand & ~kp.hand) nxt_cur.hand_mode = 1'b1;
            else if (k.auto_key & ~kp.auto_key) nxt_cur.hand_mode = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cur_ff <= '{state: KRTC_IDLE, default: '0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    always_comb begin
        user_save_pulse       = cur_ff.save_req;
        user_erase_pulse      = cur_ff.erase_req;
        factory_restore_pulse = cur_ff.factory_req;
        user_restore_pulse    = cur_ff.user_req;
        user_set_present      = cur_ff.user_present;
        trip_latched          = cur_ff.tripped;
        output_enable         = ~cur_ff.tripped;
        fault_code            = cur_ff.fault_code;
        active_source         = cur_ff.hand_mode ? SRC_KEYPAD : control_source_select;
        if (cur_ff.state == KRTC_PROMPT || cur_ff.state == KRTC_RELEASE) begin
            display_mode = cur_ff.user_chord ? DISP_UDEF : DISP_PDEF;
        end else if (cur_ff.tripped) begin
            display_mode = DISP_FAULT;
        end else begin
            display_mode = DISP_RUN;
        end
    end
endmodule
`default_nettype wire

// file: verif/krtc_chk.sv
/* checker for krtc_core: stores, trips and remote clears at the ports.
   assumes one mclk domain; bound to every krtc_core instance. */
`default_nettype none
module krtc_chk import krtc_pkg::*; (
    // clock and reset
    input wire logic mclk, rst_b,
    // inputs, plus the fault_code output
    input wire logic [3:0] user_default_command, control_source_select,
    input wire logic user_default_command_wr, protect_event, fieldbus_reset, bacnet_reset,
    input wire logic [7:0] protect_code, fault_code,
    // outputs
    input wire logic user_save_pulse, user_erase_pulse, factory_restore_pulse,
    input wire logic user_restore_pulse, user_set_present, trip_latched, output_enable,
    input wire krtc_disp_type display_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    chk_enable_off: assert property (output_enable == !trip_latched)
        else $error("enable wrong");
    chk_trip_set: assert property (
        protect_event |=> trip_latched && fault_code == $past(protect_code))
        else $error("trip missed");
    chk_save_cmd: assert property (
        user_default_command_wr && user_default_command == UDC_SAVE
        |=> user_save_pulse && user_set_present) else $error("save missed");
    chk_erase_cmd: assert property (
        user_default_command_wr && user_default_command == UDC_CLEAR
        |=> user_erase_pulse && !user_set_present ##1 !user_erase_pulse) else $error("erase bad");
    chk_fbus_clear: assert property (
        trip_latched && fieldbus_reset && control_source_select == SRC_FIELDBUS && !protect_event
        |=> !trip_latched) else $error("fieldbus clear");
    chk_bacnet_clear: assert property (
        trip_latched && bacnet_reset && control_source_select == SRC_BACNET && !protect_event
        |=> !trip_latched) else $error("bacnet clear");
    chk_factory_done: assert property (
        factory_restore_pulse |=> !factory_restore_pulse && display_mode == DISP_RUN)
        else $error("factory bad");
    chk_user_set: assert property (user_restore_pulse |-> user_set_present)
        else $error("user restore bad");
endmodule
bind krtc_core krtc_chk krtc_chk_inst (.mclk, .rst_b, .user_default_command,
    .control_source_select, .user_default_command_wr, .protect_event, .fieldbus_reset,
    .bacnet_reset, .protect_code, .fault_code, .user_save_pulse, .user_erase_pulse,
    .factory_restore_pulse, .user_restore_pulse, .user_set_present, .trip_latched,
    .output_enable, .display_mode);
`default_nettype wire

// file: verif/krtc_oper.sv
/* keypad operator and digital input model.
   assumes calls are made from the bench on mclk. */
`default_nettype none
module krtc_oper import krtc_pkg::*; (
    input wire logic mclk,
    output var krtc_keys_type keys_pin,
    output var logic din1_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial keys_pin = '0;
    initial din1_pin = 1'h1;
    // a slow operator is only a longer hold
    task automatic press(input krtc_keys_type k, input int n);
        @(posedge mclk) keys_pin <= k;
        repeat (n) @(posedge mclk);
        keys_pin <= '0;
        repeat (8) @(posedge mclk);
    endtask
    task automatic toggle_din();
        @(posedge mclk) din1_pin <= 1'h0;
        repeat (8) @(posedge mclk);
        din1_pin <= 1'h1;
        repeat (8) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
/* self-checking bench for krtc_core against an integer model.
   assumes krtc_pkg, krtc_core, krtc_chk and krtc_oper compiled first. */
`default_nettype none
module testbench import krtc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0, rst_b = 1'h0, din1_pin, user_default_command_wr = 1'h0;
    logic parameter_access_lock = 1'h0, protect_event = 1'h0, fieldbus_reset = 1'h0;
    logic bacnet_reset = 1'h0, output_enable, trip_latched, user_set_present;
    logic user_save_pulse, user_erase_pulse, factory_restore_pulse, user_restore_pulse;
    logic [3:0] user_default_command = 4'h0, input_config_select = 4'h0;
    logic [3:0] control_source_select = 4'h0, active_source;
    logic [7:0] protect_code = 8'h00, fault_code, seed = 8'h2c;
    krtc_keys_type keys_pin;
    krtc_disp_type display_mode;
    int err_count = 0, checked = 0, cyc = 0, x_trip = 0, x_pres = 0;
    int n[4] = '{0, 0, 0, 0}, e[4] = '{0, 0, 0, 0};
    krtc_core #(.HOLD_COUNT(20)) krtc_core_inst (.mclk, .rst_b, .keys_pin, .din1_pin,
        .user_default_command, .user_default_command_wr, .input_config_select,
        .control_source_select, .parameter_access_lock, .protect_event, .protect_code,
        .fieldbus_reset, .bacnet_reset, .user_save_pulse, .user_erase_pulse,
        .factory_restore_pulse, .user_restore_pulse, .user_set_present, .trip_latched,
        .output_enable, .fault_code, .display_mode, .active_source);
    krtc_oper krtc_oper_inst (.mclk, .keys_pin, .din1_pin);
    initial forever #2 mclk = ~mclk;
    task automatic complete_run();
        if (err_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // pulses are counted so a doubled or missing pulse shows in the totals
    always @(posedge mclk) begin
        cyc++;
        n[0] += (user_save_pulse === 1'h1);
        n[1] += (user_erase_pulse === 1'h1);
        n[2] += (factory_restore_pulse === 1'h1);
        n[3] += (user_restore_pulse === 1'h1);
        if (cyc == 4000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x) begin
            err_count++;
            $display("BAD %s expected %0h seen %0h", nm, x, s);
        end
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic check_all();
        chk("trip", trip_latched, x_trip);
        chk("oe", output_enable, !x_trip);
        chk("pres", user_set_present, x_pres);
        for (int i = 0; i < 4; i++)
            chk("cnt", n[i], e[i]);
    endtask
    task automatic wr_cmd(input logic [3:0] v);
        @(posedge mclk);
        user_default_command <= v;
        user_default_command_wr <= 1'h1;
        @(posedge mclk);
        user_default_command_wr <= 1'h0;
        repeat (2) @(posedge mclk);
        if (v == UDC_SAVE) e[0]++;
        if (v == UDC_CLEAR) e[1]++;
        if (v inside {UDC_SAVE, UDC_CLEAR}) x_pres = (v == UDC_SAVE);
        check_all();
    endtask
    task automatic chord(input krtc_keys_type k, input krtc_disp_type d, input krtc_keys_type t);
        krtc_oper_inst.press(k, 30);
        chk("disp", display_mode, d);
        krtc_oper_inst.press(t, 2);
        chk("disp", display_mode, DISP_RUN);
        check_all();
    endtask
    task automatic trip();
        @(posedge mclk);
        protect_event <= 1'h1;
        protect_code <= seed;
        @(posedge mclk);
        protect_event <= 1'h0;
        seed = lfsr(seed);
        repeat (2) @(posedge mclk);
        x_trip = 1;
        chk("flt", fault_code, protect_code);
        chk("disp", display_mode, DISP_FAULT);
    endtask
    task automatic remote(input logic bn, input logic [3:0] src, input int clr);
        @(posedge mclk);
        control_source_select <= src;
        fieldbus_reset <= !bn;
        bacnet_reset <= bn;
        @(posedge mclk);
        fieldbus_reset <= 1'h0;
        bacnet_reset <= 1'h0;
        repeat (2) @(posedge mclk);
        if (clr) x_trip = 0;
        check_all();
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'h1;
        @(posedge mclk);
        check_all();
        wr_cmd(4'h3);
        wr_cmd(UDC_CLEAR);
        e[2]++;
        chord(7'h68, DISP_UDEF, 7'h08);
        e[2]++;
        chord(7'h58, DISP_PDEF, 7'h08);
        wr_cmd(UDC_SAVE);
        e[3]++;
        chord(7'h68, DISP_UDEF, 7'h08);
        chord(7'h58, DISP_PDEF, 7'h01);
        chord(7'h68, DISP_UDEF, 7'h40);
        trip();
        krtc_oper_inst.press(7'h08, 2);
        x_trip = 0;
        check_all();
        trip();
        krtc_oper_inst.toggle_din();
        check_all();
        input_config_select <= seed[3:0] | 4'h1;
        krtc_oper_inst.toggle_din();
        x_trip = 0;
        check_all();
        trip();
        remote(1'h0, SRC_BACNET, 0);
        remote(1'h0, SRC_FIELDBUS, 1);
        trip();
        remote(1'h1, SRC_FIELDBUS, 0);
        remote(1'h1, SRC_BACNET, 1);
        krtc_oper_inst.press(7'h04, 2);
        chk("src", active_source, SRC_KEYPAD);
        parameter_access_lock <= 1'h1;
        krtc_oper_inst.press(7'h02, 2);
        chk("src", active_source, SRC_KEYPAD);
        parameter_access_lock <= 1'h0;
        krtc_oper_inst.press(7'h02, 2);
        chk("src", active_source, SRC_BACNET);
        complete_run();
    end
endmodule
`default_nettype wire
